// File: rtl/epv_map.vh
// register map, field positions, codes and reset values of the position report block
`ifndef EPV_MAP_VH
`define EPV_MAP_VH

`define EPV_ADDR_W 6
`define EPV_A_FINE_RES 6'h00
`define EPV_A_PROBE_SEL 6'h04
`define EPV_A_IRQ_STAT 6'h08
`define EPV_A_IRQ_MASK 6'h0C
`define EPV_A_STATUS 6'h10
`define EPV_A_E1_WORD_A 6'h14
`define EPV_A_E1_WORD_B 6'h18
`define EPV_A_E2_WORD_A 6'h1C
`define EPV_A_E2_WORD_B 6'h20

`define EPV_FR_W 5
`define EPV_FR_A_LSB 0
`define EPV_FR_B_LSB 8
`define EPV_FR_CH_STEP 16
`define EPV_FR_A_RST 5'h02
`define EPV_FR_B_RST 5'h02

`define EPV_PSEL_W 4
`define EPV_PSEL1_LSB 0
`define EPV_PSEL2_LSB 8
`define EPV_PSEL_NONE 4'h0

`define EPV_IRQ_W 4
`define EPV_IRQ_ERR_LSB 0
`define EPV_IRQ_CAP_LSB 2

`define EPV_ZSW_FUNC_LSB 0
`define EPV_ZSW_AVAIL_LSB 4
`define EPV_ZSW_ABS_ACK 13
`define EPV_ZSW_PARK 14
`define EPV_ZSW_ERR 15

`define EPV_CODE_W 16
`define EPV_CODE_NONE 16'h0000
`define EPV_CODE_ENC 16'h0001
`define EPV_CODE_ZMON 16'h0002
`define EPV_CODE_PARK 16'h0003
`define EPV_CODE_REF 16'h0004
`define EPV_CODE_GETREF 16'h0005
`define EPV_CODE_FLY 16'h0006
`define EPV_CODE_GETMEAS 16'h0007
`define EPV_CODE_ABS 16'h0008
`define EPV_CODE_UNSUP 16'h0F01

`define EPV_NUM_W 3
`define EPV_NUM_NONE 3'h0
`define EPV_NUM_ONE 3'h1
`define EPV_NUM_MAX 3'h4
`define EPV_MARK_FIRST 4'h1

`endif

// File: rtl/epv_top.v
// cyclic encoder position words and status words for two encoder channels
`timescale 1ns/100ps
`include "epv_map.vh"

module epv_top #(
    parameter NCH = 2,
    parameter POS_W = 32
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [`EPV_ADDR_W-1:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [31:0] bus_rdata,
    output reg irq,
    input wire [NCH-1:0] enc_step,
    input wire [NCH-1:0] enc_dir,
    input wire [NCH-1:0] enc_fault,
    input wire [NCH-1:0] zero_mon_fail,
    input wire [NCH-1:0] zero_mark_pulse,
    input wire [NCH-1:0] has_zero_mark,
    input wire [NCH-1:0] dist_code_bad,
    input wire [NCH-1:0] probe_edge,
    input wire [NCH-1:0] abs_present,
    input wire [NCH-1:0] abs_alarm,
    input wire [NCH*POS_W-1:0] abs_value,
    input wire [NCH-1:0] park_do_selected,
    input wire [NCH-1:0] func_unsupported,
    input wire [NCH-1:0] req_ref_search,
    input wire [NCH*4-1:0] req_ref_mark,
    input wire [NCH-1:0] req_flying,
    input wire [NCH*`EPV_NUM_W-1:0] req_read_num,
    input wire [NCH-1:0] req_abs_cyclic,
    input wire [NCH-1:0] req_park,
    output wire [15:0] enc1_status_word,
    output wire [POS_W-1:0] enc1_position_word_a,
    output wire [POS_W-1:0] enc1_position_word_b,
    output wire [15:0] enc2_status_word,
    output wire [POS_W-1:0] enc2_position_word_a,
    output wire [POS_W-1:0] enc2_position_word_b
);

    reg [`EPV_FR_W-1:0] fr_a_reg [0:NCH-1];
    reg [`EPV_FR_W-1:0] fr_b_reg [0:NCH-1];
    reg [`EPV_PSEL_W-1:0] probe1_input_select_reg;
    reg [`EPV_PSEL_W-1:0] probe2_input_select_reg;
    reg [`EPV_IRQ_W-1:0] irq_stat_reg;
    reg [`EPV_IRQ_W-1:0] irq_mask_reg;
    reg [`EPV_IRQ_W-1:0] irq_stat_next;
    reg [`EPV_IRQ_W-1:0] irq_mask_next;
    reg [POS_W-1:0] word_a_reg [0:NCH-1];
    reg [POS_W-1:0] word_b_reg [0:NCH-1];
    reg [15:0] zsw_reg [0:NCH-1];
    wire [NCH-1:0] err_event;
    wire [NCH-1:0] cap_event;
    wire probe_cfg;
    wire wr_fine;

    assign probe_cfg = (probe1_input_select_reg != `EPV_PSEL_NONE) ||
        (probe2_input_select_reg != `EPV_PSEL_NONE);
    assign wr_fine = bus_wr && (bus_addr == `EPV_A_FINE_RES);

    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : ch
            reg [POS_W-1:0] cnt_reg;
            reg [POS_W-1:0] ref_val_reg;
            reg [POS_W-1:0] meas_val_reg;
            reg ref_avail_reg;
            reg meas_avail_reg;
            reg err_seen_reg;
            reg fly_run_reg;
            reg [`EPV_CODE_W-1:0] code;
            reg [POS_W-1:0] val_b;
            reg [15:0] zsw_next;
            reg abs_ok;
            wire ref_act;
            wire fly_act;
            wire [3:0] mark;
            wire [`EPV_NUM_W-1:0] rnum;
            wire rd_req;
            wire [POS_W-1:0] absv;

            assign mark = req_ref_mark[c*4 +: 4];
            assign rnum = req_read_num[c*`EPV_NUM_W +: `EPV_NUM_W];
            assign rd_req = (rnum != `EPV_NUM_NONE);
            assign absv = abs_value[c*POS_W +: POS_W];
            assign ref_act = req_ref_search[c] && !req_park[c];
            assign fly_act = req_flying[c] && !req_park[c];

            // line count; one sin/cos period counts as one line
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_reg <= {POS_W{1'b0}};
                end else if (enc_step[c] && !req_park[c]) begin
                    // free-running, wraps through both ends
                    if (enc_dir[c]) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end

            // captured values kept until the function is dropped and no read is requested
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    ref_val_reg <= {POS_W{1'b0}};
                    meas_val_reg <= {POS_W{1'b0}};
                    ref_avail_reg <= 1'b0;
                    meas_avail_reg <= 1'b0;
                    err_seen_reg <= 1'b0;
                end else begin
                    err_seen_reg <= (code != `EPV_CODE_NONE);
                    if (ref_act && zero_mark_pulse[c] && !ref_avail_reg) begin
                        ref_val_reg <= cnt_reg;
                        ref_avail_reg <= 1'b1;
                    end else if (!req_ref_search[c] && !rd_req) begin
                        ref_avail_reg <= 1'b0;
                    end
                    if (fly_act && probe_cfg && probe_edge[c] && !meas_avail_reg) begin
                        meas_val_reg <= cnt_reg;
                        meas_avail_reg <= 1'b1;
                    end else if (!req_flying[c] && !rd_req) begin
                        meas_avail_reg <= 1'b0;
                    end
                end
            end

            // remembers that flying measurement ran before a search was asked for
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    fly_run_reg <= 1'b0;
                end else begin
                    fly_run_reg <= req_flying[c] && (fly_run_reg || !req_ref_search[c]);
                end
            end

            assign err_event[c] = (code != `EPV_CODE_NONE) && !err_seen_reg;
            assign cap_event[c] = (ref_act && zero_mark_pulse[c] && !ref_avail_reg) ||
                (fly_act && probe_cfg && probe_edge[c] && !meas_avail_reg);

            // error code selection, most severe cause first
            always @* begin
                code = `EPV_CODE_NONE;
                abs_ok = abs_present[c] && !abs_alarm[c];
                if (enc_fault[c]) begin
                    code = `EPV_CODE_ENC;
                end else if (zero_mon_fail[c]) begin
                    code = `EPV_CODE_ZMON;
                end else if (req_park[c] && park_do_selected[c]) begin
                    code = `EPV_CODE_PARK;
                end else if (func_unsupported[c]) begin
                    code = `EPV_CODE_UNSUP;
                end else if (req_ref_search[c] && !(fly_run_reg && req_flying[c])) begin
                    // marks 2 to 4 not searched; read or flying mode aborts search
                    if (!has_zero_mark[c] || (mark != `EPV_MARK_FIRST) ||
                        req_flying[c] || rd_req || dist_code_bad[c]) begin
                        code = `EPV_CODE_REF;
                    end
                end else if (req_flying[c]) begin
                    // a search asked for during a running measurement aborts the measurement
                    if (!probe_cfg || rd_req || req_park[c] || req_ref_search[c]) begin
                        code = `EPV_CODE_FLY;
                    end
                end else if (rd_req && ref_avail_reg) begin
                    // only reference value 1 is held
                    if ((rnum > `EPV_NUM_MAX) || (rnum != `EPV_NUM_ONE)) begin
                        code = `EPV_CODE_GETREF;
                    end
                end else if (rd_req && meas_avail_reg) begin
                    if ((rnum != `EPV_NUM_ONE) || req_park[c] ||
                        park_do_selected[c]) begin
                        code = `EPV_CODE_GETMEAS;
                    end
                end else if (rd_req) begin
                    // nothing held: a reference fetch is assumed
                    code = `EPV_CODE_GETREF;
                end else if (req_abs_cyclic[c] && !abs_ok) begin
                    code = `EPV_CODE_ABS;
                end
            end

            // word b content by priority: error, fetched value, absolute value
            always @* begin
                val_b = {POS_W{1'b0}};
                if (code != `EPV_CODE_NONE) begin
                    val_b = {{(POS_W-`EPV_CODE_W){1'b0}}, code};
                end else if (rd_req && ref_avail_reg) begin
                    val_b = ref_val_reg << fr_b_reg[c];
                end else if (rd_req && meas_avail_reg) begin
                    val_b = meas_val_reg << fr_b_reg[c];
                end else if (req_abs_cyclic[c] && !req_park[c]) begin
                    val_b = absv << fr_b_reg[c];
                end
            end

            always @* begin
                zsw_next = 16'h0000;
                zsw_next[`EPV_ZSW_FUNC_LSB] = ref_act || fly_act;
                zsw_next[`EPV_ZSW_AVAIL_LSB] = ref_avail_reg || meas_avail_reg;
                zsw_next[`EPV_ZSW_ABS_ACK] = req_abs_cyclic[c] && abs_ok && !rd_req &&
                    (code == `EPV_CODE_NONE);
                zsw_next[`EPV_ZSW_PARK] = req_park[c] && !park_do_selected[c];
                zsw_next[`EPV_ZSW_ERR] = (code != `EPV_CODE_NONE);
            end

            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    word_a_reg[c] <= {POS_W{1'b0}};
                    word_b_reg[c] <= {POS_W{1'b0}};
                    zsw_reg[c] <= 16'h0000;
                end else begin
                    // plain shift: no modulo, bits shifted out are lost
                    word_a_reg[c] <= cnt_reg << fr_a_reg[c];
                    word_b_reg[c] <= val_b;
                    zsw_reg[c] <= zsw_next;
                end
            end

            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    fr_a_reg[c] <= `EPV_FR_A_RST;
                    fr_b_reg[c] <= `EPV_FR_B_RST;
                end else if (wr_fine) begin
                    fr_a_reg[c] <= bus_wdata[c*`EPV_FR_CH_STEP+`EPV_FR_A_LSB +: `EPV_FR_W];
                    fr_b_reg[c] <= bus_wdata[c*`EPV_FR_CH_STEP+`EPV_FR_B_LSB +: `EPV_FR_W];
                end
            end
        end
    endgenerate

    // the controller owns wrap detection of word a
    assign enc1_status_word = zsw_reg[0];
    assign enc1_position_word_a = word_a_reg[0];
    assign enc1_position_word_b = word_b_reg[0];
    assign enc2_status_word = zsw_reg[1];
    assign enc2_position_word_a = word_a_reg[1];
    assign enc2_position_word_b = word_b_reg[1];

    // sticky events: a new event wins over a clear in the same cycle
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (bus_wr && (bus_addr == `EPV_A_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~bus_wdata[`EPV_IRQ_W-1:0];
        end
        irq_stat_next[`EPV_IRQ_ERR_LSB +: NCH] =
            irq_stat_next[`EPV_IRQ_ERR_LSB +: NCH] | err_event;
        irq_stat_next[`EPV_IRQ_CAP_LSB +: NCH] =
            irq_stat_next[`EPV_IRQ_CAP_LSB +: NCH] | cap_event;
    end

    // the mask is taken at its next value so a mask write reaches irq at once
    always @* begin
        irq_mask_next = irq_mask_reg;
        if (bus_wr && (bus_addr == `EPV_A_IRQ_MASK)) begin
            irq_mask_next = bus_wdata[`EPV_IRQ_W-1:0];
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_reg <= {`EPV_IRQ_W{1'b0}};
            irq_mask_reg <= {`EPV_IRQ_W{1'b0}};
            irq <= 1'b0;
            probe1_input_select_reg <= `EPV_PSEL_NONE;
            probe2_input_select_reg <= `EPV_PSEL_NONE;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq <= |(irq_stat_next & irq_mask_next);
            if (bus_wr && (bus_addr == `EPV_A_PROBE_SEL)) begin
                probe1_input_select_reg <= bus_wdata[`EPV_PSEL1_LSB +: `EPV_PSEL_W];
                probe2_input_select_reg <= bus_wdata[`EPV_PSEL2_LSB +: `EPV_PSEL_W];
            end
        end
    end

    // read data valid only in the cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (!bus_rd) begin
            bus_rdata <= 32'h0000_0000;
        end else begin
            case (bus_addr)
                `EPV_A_FINE_RES: begin
                    bus_rdata <= {3'h0, fr_b_reg[1], 3'h0, fr_a_reg[1],
                        3'h0, fr_b_reg[0], 3'h0, fr_a_reg[0]};
                end
                `EPV_A_PROBE_SEL: begin
                    bus_rdata <= {20'h0_0000, probe2_input_select_reg,
                        4'h0, probe1_input_select_reg};
                end
                `EPV_A_IRQ_STAT: begin
                    bus_rdata <= {28'h000_0000, irq_stat_reg};
                end
                `EPV_A_IRQ_MASK: begin
                    bus_rdata <= {28'h000_0000, irq_mask_reg};
                end
                `EPV_A_STATUS: begin
                    bus_rdata <= {zsw_reg[1], zsw_reg[0]};
                end
                `EPV_A_E1_WORD_A: begin
                    bus_rdata <= word_a_reg[0];
                end
                `EPV_A_E1_WORD_B: begin
                    bus_rdata <= word_b_reg[0];
                end
                `EPV_A_E2_WORD_A: begin
                    bus_rdata <= word_a_reg[1];
                end
                `EPV_A_E2_WORD_B: begin
                    bus_rdata <= word_b_reg[1];
                end
                default: begin
                    bus_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// File: tb/epv_assertions.sv
// port-level checks for the position report block
`timescale 1ns/100ps
`include "epv_map.vh"
module epv_check #(
    parameter NCH = 2,
    parameter POS_W = 32
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [`EPV_ADDR_W-1:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire [NCH-1:0] enc_step,
    input wire [NCH-1:0] enc_dir,
    input wire [NCH-1:0] enc_fault,
    input wire [NCH-1:0] zero_mon_fail,
    input wire [NCH-1:0] park_do_selected,
    input wire [NCH-1:0] func_unsupported,
    input wire [NCH-1:0] req_park,
    input wire [15:0] enc1_status_word,
    input wire [POS_W-1:0] enc1_position_word_a,
    input wire [POS_W-1:0] enc1_position_word_b,
    input wire [15:0] enc2_status_word,
    input wire [POS_W-1:0] enc2_position_word_a,
    input wire [POS_W-1:0] enc2_position_word_b
);
    reg [4:0] fr_a_reg;
    wire [POS_W-1:0] inc = {{(POS_W-1){1'b0}}, 1'b1} << fr_a_reg;
    wire hi0 = !enc_fault[0] && !zero_mon_fail[0];
    // shadow of the word a resolution, so step size can be predicted
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fr_a_reg <= `EPV_FR_A_RST;
        end else if (bus_wr && bus_addr == `EPV_A_FINE_RES) begin
            fr_a_reg <= bus_wdata[4:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // no write around the step: a new resolution would rescale the whole count
    property p_step;
        enc_step[0] && !req_park[0] && !bus_wr ##1 !bus_wr |=>
            enc1_position_word_a == $past(enc1_position_word_a) + ($past(enc_dir[0], 2) ? -inc : inc);
    endproperty
    a_step: assert property (p_step) else $error("word a step size wrong");
    property p_rst_zero;
        $fell(sys_rst) |-> enc1_position_word_a == '0 && enc2_position_word_a == '0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("word a not zero after reset");
    property p_code_enc;
        enc_fault[0] |=> enc1_position_word_b == `EPV_CODE_ENC;
    endproperty
    a_code_enc: assert property (p_code_enc) else $error("fault code missing");
    property p_err_flag;
        enc_fault[0] || zero_mon_fail[0] |=> enc1_status_word[`EPV_ZSW_ERR];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag missing");
    property p_zmon;
        !enc_fault[0] && zero_mon_fail[0] |=> enc1_position_word_b == `EPV_CODE_ZMON;
    endproperty
    a_zmon: assert property (p_zmon) else $error("zero mark code missing");
    property p_park;
        hi0 && req_park[0] && park_do_selected[0] |=>
            enc1_position_word_b == `EPV_CODE_PARK && enc1_status_word[`EPV_ZSW_ERR];
    endproperty
    a_park: assert property (p_park) else $error("park abort code missing");
    property p_unsup;
        hi0 && !(req_park[0] && park_do_selected[0]) && func_unsupported[0] |=>
            enc1_position_word_b == `EPV_CODE_UNSUP;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported code missing");
    property p_ch2;
        enc_fault[1] |=> enc2_position_word_b == `EPV_CODE_ENC && enc2_status_word[`EPV_ZSW_ERR];
    endproperty
    a_ch2: assert property (p_ch2) else $error("channel 2 fault report wrong");
    c_down: cover property (enc_step[0] && enc_dir[0]);
    c_fault: cover property (enc_fault[0] ##1 enc1_status_word[`EPV_ZSW_ERR]);
    c_unsup: cover property (hi0 && func_unsupported[0]);
endmodule

// File: tb/epv_master_model.sv
// master controller side: extends word a across its binary rollover
`timescale 1ns/100ps
module epv_master_model #(
    parameter POS_W = 32
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [POS_W-1:0] position_word_a,
    output reg signed [63:0] pos_ext
);
    reg [POS_W-1:0] prev_reg;
    // word a is relative, so only the signed difference between cycles counts
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prev_reg <= '0;
            pos_ext <= 64'sh0;
        end else begin
            prev_reg <= position_word_a;
            pos_ext <= pos_ext + $signed(position_word_a - prev_reg);
        end
    end
endmodule

// File: tb/encoder_position_value_report_test.sv
// self-checking bench for the position report block
`timescale 1ns/100ps
`include "epv_map.vh"
module encoder_position_value_report_test;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg [5:0] bus_addr = 6'h00;
    reg [31:0] bus_wdata = 32'h0000_0000;
    reg bus_wr = 1'b0, bus_rd = 1'b0;
    reg [1:0] enc_step = 2'h0, enc_dir = 2'h0, enc_fault = 2'h0, zero_mon_fail = 2'h0;
    reg [1:0] has_zero_mark = 2'h0, abs_present = 2'h0, abs_alarm = 2'h0, req_park = 2'h0;
    reg [1:0] park_do_selected = 2'h0, func_unsupported = 2'h0, req_ref_search = 2'h0;
    reg [1:0] req_flying = 2'h0, req_abs_cyclic = 2'h0;
    reg [1:0] zero_mark_pulse = 2'h0, dist_code_bad = 2'h0, probe_edge = 2'h0;
    reg [7:0] req_ref_mark = 8'h11;
    reg [5:0] req_read_num = 6'h00;
    wire [31:0] bus_rdata, w1a, w1b, w2a, w2b;
    wire [15:0] s1, s2;
    wire irq;
    wire signed [63:0] pos_ext;
    int error_cnt = 0;
    int tests_run = 0;
    epv_top #(.NCH(2), .POS_W(32)) epv_top_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .enc_step(enc_step), .enc_dir(enc_dir), .enc_fault(enc_fault),
        .zero_mon_fail(zero_mon_fail), .zero_mark_pulse(zero_mark_pulse),
        .has_zero_mark(has_zero_mark), .dist_code_bad(dist_code_bad),
        .probe_edge(probe_edge), .abs_present(abs_present),
        .abs_alarm(abs_alarm), .abs_value(64'h0000_0000_0000_1234),
        .park_do_selected(park_do_selected), .func_unsupported(func_unsupported),
        .req_ref_search(req_ref_search), .req_ref_mark(req_ref_mark), .req_flying(req_flying),
        .req_read_num(req_read_num), .req_abs_cyclic(req_abs_cyclic), .req_park(req_park),
        .enc1_status_word(s1), .enc1_position_word_a(w1a), .enc1_position_word_b(w1b),
        .enc2_status_word(s2), .enc2_position_word_a(w2a), .enc2_position_word_b(w2b)
    );
    epv_master_model #(.POS_W(32)) epv_master_model_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .position_word_a(w1a), .pos_ext(pos_ext)
    );
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task bus_write(input [5:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            bus_wr <= 1'b1;
            bus_addr <= a;
            bus_wdata <= d;
            @(posedge clk_sys);
            bus_wr <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe, so take it there
    task bus_read(input [5:0] a, output [31:0] d);
        begin
            @(posedge clk_sys);
            bus_rd <= 1'b1;
            bus_addr <= a;
            @(posedge clk_sys);
            bus_rd <= 1'b0;
            #1 d = bus_rdata;
        end
    endtask
    task step(input integer ch, input dir, input integer n);
        begin
            @(posedge clk_sys);
            enc_step[ch] <= 1'b1;
            enc_dir[ch] <= dir;
            repeat (n) @(posedge clk_sys);
            enc_step[ch] <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
        end
    endtask
    task t_reset;
        reg [31:0] d;
        begin
            @(posedge clk_sys);
            #1 chk("word_a", 32'h0000_0000, w1a);
            bus_read(`EPV_A_FINE_RES, d);
            chk("fine_res", 32'h0202_0202, d);
            bus_read(6'h3C, d);
            chk("unmapped", 32'h0000_0000, d);
        end
    endtask
    task t_count;
        reg [31:0] d;
        begin
            bus_write(`EPV_A_FINE_RES, 32'h0202_0203);
            step(0, 1'b0, 5);
            chk("up5", 32'h0000_0028, w1a);
            step(0, 1'b1, 7);
            chk("wrap", 32'hFFFF_FFF0, w1a);
            chk("ext_lo", 32'hFFFF_FFF0, pos_ext[31:0]);
            chk("ext_hi", 32'hFFFF_FFFF, pos_ext[63:32]);
            bus_read(`EPV_A_E1_WORD_A, d);
            chk("rd_word_a", 32'hFFFF_FFF0, d);
            step(1, 1'b0, 1);
            chk("word_a2", 32'h0000_0004, w2a);
        end
    endtask
    task do_case(input [14:0] c, input [2:0] n, input [31:0] e, input s);
        begin
            @(posedge clk_sys);
            {probe_edge[0], zero_mark_pulse[0], dist_code_bad[0], req_ref_mark[3:0],
                enc_fault[0], zero_mon_fail[0], req_park[0], park_do_selected[0],
                func_unsupported[0], req_ref_search[0], has_zero_mark[0], req_flying[0],
                req_abs_cyclic[0], abs_present[0], abs_alarm[0]} <=
                {c[14:12], c[11] ? 4'h2 : 4'h1, c[10:0]};
            req_read_num[2:0] <= n;
            repeat (3) @(posedge clk_sys);
            #1 chk("word_b", e, w1b);
            chk("err_flag", {31'h0, s}, {31'h0, s1[`EPV_ZSW_ERR]});
        end
    endtask
    task t_codes;
        begin
            do_case(12'h640, 3'h0, `EPV_CODE_ENC, 1'b1);
            do_case(12'h380, 3'h0, `EPV_CODE_ZMON, 1'b1);
            do_case(12'h1C0, 3'h0, `EPV_CODE_PARK, 1'b1);
            do_case(12'h070, 3'h0, `EPV_CODE_UNSUP, 1'b1);
            do_case(12'h020, 3'h0, `EPV_CODE_REF, 1'b1);
            do_case(12'h830, 3'h0, `EPV_CODE_REF, 1'b1);
            do_case(12'h008, 3'h0, `EPV_CODE_FLY, 1'b1);
            do_case(12'h000, 3'h5, `EPV_CODE_GETREF, 1'b1);
            do_case(12'h004, 3'h0, `EPV_CODE_ABS, 1'b1);
            do_case(12'h007, 3'h0, `EPV_CODE_ABS, 1'b1);
            do_case(12'h006, 3'h0, 16'h48D0, 1'b0);
            chk("abs_ack", 32'h1, {31'h0, s1[`EPV_ZSW_ABS_ACK]});
            do_case(12'h000, 3'h0, `EPV_CODE_NONE, 1'b0);
        end
    endtask
    // channel 0 count stands at -2 here and word b resolution is 2
    task t_capture;
        begin
            bus_write(`EPV_A_PROBE_SEL, 32'h0000_0001);
            do_case(15'h2030, 3'h0, `EPV_CODE_NONE, 1'b0);
            chk("held", 32'h1, {31'h0, s1[`EPV_ZSW_AVAIL_LSB]});
            do_case(15'h0000, 3'h1, 32'hFFFF_FFF8, 1'b0);
            do_case(15'h0000, 3'h2, `EPV_CODE_GETREF, 1'b1);
            do_case(15'h1030, 3'h0, `EPV_CODE_REF, 1'b1);
            do_case(15'h4008, 3'h0, `EPV_CODE_NONE, 1'b0);
            do_case(15'h0008, 3'h1, `EPV_CODE_FLY, 1'b1);
            do_case(15'h0028, 3'h0, `EPV_CODE_FLY, 1'b1);
            do_case(15'h0000, 3'h1, 32'hFFFF_FFF8, 1'b0);
            do_case(15'h0000, 3'h2, `EPV_CODE_GETMEAS, 1'b1);
            do_case(15'h0000, 3'h0, `EPV_CODE_NONE, 1'b0);
        end
    endtask
    // channel 2 event stays masked out, so irq must drop once bit 0 is cleared
    task t_irq;
        reg [31:0] d;
        begin
            bus_write(`EPV_A_IRQ_STAT, 32'h0000_000F);
            bus_write(`EPV_A_IRQ_MASK, 32'h0000_0001);
            @(posedge clk_sys);
            enc_fault <= 2'h3;
            repeat (3) @(posedge clk_sys);
            #1 chk("irq_on", 32'h1, {31'h0, irq});
            chk("word_b2", {16'h0000, `EPV_CODE_ENC}, w2b);
            bus_read(`EPV_A_IRQ_STAT, d);
            chk("irq_stat", 32'h0000_0003, d);
            bus_write(`EPV_A_IRQ_STAT, 32'h0000_0001);
            repeat (2) @(posedge clk_sys);
            #1 chk("irq_off", 32'h0, {31'h0, irq});
            bus_read(`EPV_A_IRQ_STAT, d);
            chk("irq_stat2", 32'h0000_0002, d);
            enc_fault <= 2'h0;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_count;
        t_codes;
        t_capture;
        t_irq;
        give_verdict;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        give_verdict;
    end
endmodule
bind epv_top epv_check #(.NCH(NCH), .POS_W(POS_W)) epv_check_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .enc_step(enc_step), .enc_dir(enc_dir), .enc_fault(enc_fault),
    .zero_mon_fail(zero_mon_fail), .park_do_selected(park_do_selected),
    .func_unsupported(func_unsupported), .req_park(req_park),
    .enc1_status_word(enc1_status_word), .enc1_position_word_a(enc1_position_word_a),
    .enc1_position_word_b(enc1_position_word_b), .enc2_status_word(enc2_status_word),
    .enc2_position_word_a(enc2_position_word_a), .enc2_position_word_b(enc2_position_word_b)
);
